// *** rtl/crs_pkg.sv ***
// Package for the per-channel converter result store.
// Assumes a 32-bit APB and a converter core on the same pclk.
package crs_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int unsigned NUM_CHAN = 12;
   localparam int unsigned NUM_SEQ  = 2;
   localparam int unsigned RES_W    = 12;
   localparam int unsigned CHAN_W   = 4;

   // ----------------------------------------------------------------
   // Register byte addresses
   // ----------------------------------------------------------------
   localparam logic [31:0] CHAN_RESULT_0_ADDR  = 32'h4001c020;
   localparam logic [31:0] CHAN_RESULT_11_ADDR = 32'h4001c04c;
   localparam logic [31:0] OVR_FLAGS_ADDR      = 32'h4001c080;

   // ----------------------------------------------------------------
   // Field positions of a channel result word
   // ----------------------------------------------------------------
   localparam int unsigned RESULT_LSB   = 4;
   localparam int unsigned RANGE_LSB    = 16;
   localparam int unsigned CROSS_LSB    = 18;
   localparam int unsigned CHAN_LSB     = 26;
   localparam int unsigned OVERRUN_BIT  = 30;
   localparam int unsigned VALID_BIT    = 31;

   // ----------------------------------------------------------------
   // Code values and reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] RANGE_IN    = 2'h0;
   localparam logic [1:0] RANGE_BELOW = 2'h1;
   localparam logic [1:0] RANGE_ABOVE = 2'h2;
   localparam logic [1:0] CROSS_NONE  = 2'h0;
   localparam logic [1:0] CROSS_DOWN  = 2'h2;
   localparam logic [1:0] CROSS_UP    = 2'h3;
   localparam logic [11:0] RESULT_RST = 12'h000;
   localparam logic        MODE_END_OF_SEQ = 1'b1;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [CHAN_W-1:0] channel;
      logic [RES_W-1:0]  value;
      logic              seq;
   } crs_conv_t;

   typedef struct packed {
      logic [RES_W-1:0] low_limit;
      logic [RES_W-1:0] high_limit;
   } crs_thr_t;

   typedef struct packed {
      logic [RES_W-1:0] value;
      logic [1:0]       range_code;
      logic [1:0]       crossing_code;
      logic             overrun;
      logic             valid_flag;
   } crs_chan_t;

endpackage : crs_pkg

// *** rtl/crs_result_store.sv ***
// Per-channel conversion result store with its APB register slave.
// Assumes converter completions, global-read notices and threshold
// values come from logic on pclk, so none of them is synchronised.
`timescale 1ns/1ps

module crs_result_store
   import crs_pkg::*;
(
   // APB clock and reset
   input  wire logic                pclk,
   input  wire logic                presetn,
   // APB slave
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [31:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   // Converter completions
   input  wire logic                conv_done,
   input  wire crs_conv_t           conv,
   // Global result register reads
   input  wire logic                gread_done,
   input  wire logic [CHAN_W-1:0]   gread_channel,
   // Threshold pairs and per-channel pair select
   input  wire crs_thr_t            thr_pair [NUM_SEQ],
   input  wire logic [NUM_CHAN-1:0] thr_select,
   // Sequence modes
   input  wire logic [NUM_SEQ-1:0]  seq_mode,
   // Status outputs
   output logic [NUM_CHAN-1:0]      overrun_flags,
   output logic [NUM_SEQ-1:0]       seq_overrun_req
);

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   logic [31:0] addr_offset;
   logic [3:0]  chan_index;
   logic        hit_chan;
   logic        hit_flags;
   logic        access_take;
   logic        read_take;
   logic        bad_access;
   logic [31:0] read_word;
   logic        pready_next;

   assign addr_offset = paddr - CHAN_RESULT_0_ADDR;
   assign chan_index  = addr_offset[5:2];
   assign hit_chan    = (paddr >= CHAN_RESULT_0_ADDR) && (paddr <= CHAN_RESULT_11_ADDR)
                        && (paddr[1:0] == 2'h0);
   assign hit_flags   = (paddr == OVR_FLAGS_ADDR);
   // Access is taken one edge before pready is shown, so the data and its
   // read side effect are fixed by the same edge.
   assign access_take = psel && penable && !pready;
   assign read_take   = access_take && !pwrite && hit_chan;
   assign bad_access  = pwrite || !(hit_chan || hit_flags);
   assign pready_next = access_take;

   // ----------------------------------------------------------------
   // Channel storage
   // ----------------------------------------------------------------
   crs_chan_t           chan_reg  [NUM_CHAN];
   logic [31:0]         chan_word [NUM_CHAN];
   logic [NUM_CHAN-1:0] ovr_vec;
   logic [NUM_CHAN-1:0] ovr_seq0;
   logic [NUM_CHAN-1:0] ovr_seq1;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CHAN; gi = gi + 1) begin : g_chan
         logic [CHAN_W-1:0] own_index;
         logic              upd;
         logic              clr;
         logic [RES_W-1:0]  lo;
         logic [RES_W-1:0]  hi;
         logic              now_below;
         logic [1:0]        range_next;
         logic [1:0]        cross_next;
         logic              prev_below_reg;
         logic              has_prev_reg;
         logic              seq_reg;

         assign own_index = CHAN_W'(gi);
         assign upd = conv_done && (conv.channel == own_index);
         assign clr = (read_take && (chan_index == own_index))
                      || (gread_done && (gread_channel == own_index));
         assign lo  = thr_pair[thr_select[gi]].low_limit;
         assign hi  = thr_pair[thr_select[gi]].high_limit;
         assign now_below = conv.value < lo;

         // Range classification; code 3 is unreachable
         assign range_next = now_below        ? RANGE_BELOW
                           : (conv.value > hi) ? RANGE_ABOVE
                           : RANGE_IN;

         // Crossing against the low limit, from the stored previous side
         assign cross_next = !has_prev_reg                ? CROSS_NONE
                           : (!prev_below_reg && now_below) ? CROSS_DOWN
                           : (prev_below_reg && !now_below) ? CROSS_UP
                           : CROSS_NONE;

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               chan_reg[gi]   <= '0;
               prev_below_reg <= 1'b0;
               has_prev_reg   <= 1'b0;
               seq_reg        <= 1'b0;
            end else if (upd) begin
               // Value, codes and flags change together; a completion in
               // the clearing cycle sets valid and leaves overrun clear
               chan_reg[gi].value         <= conv.value;
               chan_reg[gi].range_code    <= range_next;
               chan_reg[gi].crossing_code <= cross_next;
               chan_reg[gi].valid_flag    <= 1'b1;
               chan_reg[gi].overrun       <= chan_reg[gi].valid_flag && !clr;
               prev_below_reg             <= now_below;
               has_prev_reg               <= 1'b1;
               seq_reg                    <= conv.seq;
            end else if (clr) begin
               chan_reg[gi].valid_flag <= 1'b0;
               chan_reg[gi].overrun    <= 1'b0;
            end
         end

         // Reserved fields read as zero
         assign chan_word[gi] = {chan_reg[gi].valid_flag,
                                 chan_reg[gi].overrun,
                                 own_index,
                                 6'h00,
                                 chan_reg[gi].crossing_code,
                                 chan_reg[gi].range_code,
                                 chan_reg[gi].value,
                                 4'h0};
         assign ovr_vec[gi]  = chan_reg[gi].overrun;
         assign ovr_seq0[gi] = chan_reg[gi].overrun && !seq_reg;
         assign ovr_seq1[gi] = chan_reg[gi].overrun && seq_reg;
      end
   endgenerate

   // ----------------------------------------------------------------
   // Read data select
   // ----------------------------------------------------------------
   assign read_word = hit_chan  ? chan_word[chan_index]
                    : hit_flags ? {20'h00000, ovr_vec}
                    : 32'h00000000;

   // ----------------------------------------------------------------
   // Mode-steered overrun requests
   // ----------------------------------------------------------------
   // A sequence read through channel registers reports channel overruns
   logic [NUM_SEQ-1:0] seq_ovr_next;
   assign seq_ovr_next[0] = (seq_mode[0] == MODE_END_OF_SEQ) && (|ovr_seq0);
   assign seq_ovr_next[1] = (seq_mode[1] == MODE_END_OF_SEQ) && (|ovr_seq1);

   // ----------------------------------------------------------------
   // Output registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata          <= 32'h00000000;
         pready          <= 1'b0;
         pslverr         <= 1'b0;
         overrun_flags   <= '0;
         seq_overrun_req <= '0;
      end else begin
         pready          <= pready_next;
         pslverr         <= access_take && bad_access;
         prdata          <= (access_take && !pwrite) ? read_word : 32'h00000000;
         overrun_flags   <= ovr_vec;
         seq_overrun_req <= seq_ovr_next;
      end
   end

endmodule : crs_result_store

// *** verification/crs_result_store_sva.sv ***
// Checker for crs_result_store: APB answer timing and channel word format.
// Assumes it is bound to the store and watches its ports on pclk.
`timescale 1ns/1ps
module crs_result_store_sva
   import crs_pkg::*;
(
   // Clock, reset and APB
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Sequence status
   input wire logic [1:0]  seq_mode,
   input wire logic [1:0]  seq_overrun_req
);
   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   wire        chan_rd = pready && !pslverr && !pwrite && paddr != OVR_FLAGS_ADDR;
   wire [31:0] idx     = (paddr - CHAN_RESULT_0_ADDR) >> 2;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_access;
      psel && penable && !pready;
   endsequence
   sequence s_answer;
      pready ##1 !pready;
   endsequence
   a_one_wait: assert property (s_access |=> s_answer)
      else $error("access not answered after one wait state");
   a_ready_cause: assert property (pready |-> psel && penable && $past(psel && penable))
      else $error("pready without an access phase");
   a_write_refused: assert property (pready && pwrite |-> pslverr && prdata == 32'h0)
      else $error("write was not refused");
   a_reserved_zero: assert property (chan_rd |-> prdata[3:0] == 4'h0 && prdata[25:20] == 6'h00)
      else $error("reserved bits not zero");
   a_chan_index: assert property (chan_rd |-> prdata[29:26] == idx[3:0])
      else $error("channel index field wrong");
   a_codes_legal: assert property (chan_rd |-> prdata[17:16] != 2'h3 && prdata[19:18] != 2'h1)
      else $error("reserved range or crossing code");
   a_overrun_valid: assert property (chan_rd && prdata[30] |-> prdata[31])
      else $error("overrun shown without valid");
   a_mode_gate: assert property ((seq_overrun_req & ~$past(seq_mode)) == 2'b00)
      else $error("overrun request from a sequence in the other mode");
endmodule : crs_result_store_sva

// *** verification/tb.sv ***
// Testbench for crs_result_store: APB reads, conversions and clears.
// Assumes the design files and the bound checker are compiled before it.
`timescale 1ns/1ps
module tb;
   import crs_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic        conv_done = 0, gread_done = 0, pready, pslverr, er;
   logic [31:0] paddr = 0, prdata, rd;
   logic [3:0]  gread_channel = 0;
   logic [11:0] thr_select = 12'h020, overrun_flags;
   logic [1:0]  seq_mode = 2'b01, seq_overrun_req;
   crs_conv_t   conv = '0;
   crs_thr_t    thr_pair [NUM_SEQ] = '{'{12'h064, 12'h0c8}, '{12'h800, 12'h900}};
   int          errors = 0, n_compared = 0;
   always #4 pclk = ~pclk;
   crs_result_store dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(32'h0), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .conv_done(conv_done), .conv(conv), .gread_done(gread_done),
      .gread_channel(gread_channel), .thr_pair(thr_pair), .thr_select(thr_select),
      .seq_mode(seq_mode), .overrun_flags(overrun_flags), .seq_overrun_req(seq_overrun_req));
   // ---------------------------------------------
   // Shared tasks
   // ---------------------------------------------
   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic apb(input logic [31:0] a, input logic w);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      @(posedge pclk);
      penable <= 1'b1;
      // Answer is judged only at a rising edge; release follows that edge
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         errors++;
         tally_and_finish();
      end else begin
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask : apb
   task automatic rchk(input string n, input logic [31:0] a, input logic [31:0] e);
      apb(a, 1'b0);
      chk(n, e, rd);
   endtask : rchk
   task automatic cv(input logic [3:0] ch, input logic [11:0] v, input logic s);
      @(posedge pclk);
      conv_done <= 1'b1;
      conv <= '{ch, v, s};
      @(posedge pclk);
      conv_done <= 1'b0;
   endtask : cv
   function automatic logic [31:0] w(input logic [3:0] ch, input logic v, input logic o,
                                     input logic [1:0] c, input logic [1:0] r,
                                     input logic [11:0] x);
      return {v, o, ch, 6'h00, c, r, x, 4'h0};
   endfunction : w
   // Top nibble is the expected crossing and range code pair
   logic [15:0] code_tbl [6] = '{16'h0064, 16'h00c8, 16'h9063, 16'he0c9, 16'h9000, 16'hefff};
   task automatic t_reset;
      for (int c = 0; c < 12; c++)
         rchk("idle word", CHAN_RESULT_0_ADDR + 32'(4 * c), w(4'(c), 0, 0, 0, 0, 0));
      rchk("flags idle", OVR_FLAGS_ADDR, 32'h0);
      apb(32'h4001c050, 1'b0);
      chk("unmapped err", 32'h1, 32'(er));
      apb(CHAN_RESULT_0_ADDR, 1'b1);
      chk("write err", 32'h1, 32'(er));
      $display("t_reset done");
   endtask : t_reset
   task automatic t_codes;
      for (int i = 0; i < 6; i++) begin
         cv(4'h2, code_tbl[i][11:0], i[0]);
         rchk("code word", CHAN_RESULT_0_ADDR + 32'h8, w(4'h2, 1, 0, code_tbl[i][15:14],
              code_tbl[i][13:12], code_tbl[i][11:0]));
      end
      rchk("read clears", CHAN_RESULT_0_ADDR + 32'h8, w(4'h2, 0, 0, 2'h3, 2'h2, 12'hfff));
      cv(4'h5, 12'h7ff, 1'b0);
      rchk("pair one", CHAN_RESULT_0_ADDR + 32'h14, w(4'h5, 1, 0, 2'h0, 2'h1, 12'h7ff));
      $display("t_codes done");
   endtask : t_codes
   task automatic t_overrun;
      cv(4'h7, 12'h123, 1'b0);
      cv(4'h7, 12'h456, 1'b0);
      repeat (3) @(negedge pclk);
      chk("flag port", 32'h080, 32'(overrun_flags));
      chk("seq request", 32'h1, 32'(seq_overrun_req));
      rchk("flags reg", OVR_FLAGS_ADDR, 32'h080);
      rchk("overrun word", CHAN_RESULT_0_ADDR + 32'h1c, w(4'h7, 1, 1, 2'h0, 2'h2, 12'h456));
      rchk("cleared word", CHAN_RESULT_0_ADDR + 32'h1c, w(4'h7, 0, 0, 2'h0, 2'h2, 12'h456));
      repeat (3) @(negedge pclk);
      chk("flag cleared", 32'h0, 32'(overrun_flags));
      $display("t_overrun done");
   endtask : t_overrun
   task automatic t_gread;
      cv(4'h9, 12'h0c8, 1'b1);
      @(posedge pclk);
      gread_done <= 1'b1;
      gread_channel <= 4'h9;
      @(posedge pclk);
      gread_done <= 1'b0;
      rchk("global clear", CHAN_RESULT_0_ADDR + 32'h24, w(4'h9, 0, 0, 2'h0, 2'h0, 12'h0c8));
      $display("t_gread done");
   endtask : t_gread
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_codes();
      t_overrun();
      t_gread();
      tally_and_finish();
   end
endmodule : tb
bind crs_result_store crs_result_store_sva sva (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .seq_mode(seq_mode), .seq_overrun_req(seq_overrun_req));
